// ===== pdmc_defs.svh
// constants of the power-down mode controller: offsets, fields, reset values
`ifndef PDMC_DEFS_SVH
`define PDMC_DEFS_SVH
// register byte offsets, low address bits only
`define PDMC_A_SBY 8'h00
`define PDMC_A_LPW 8'h04
`define PDMC_A_TCS 8'h08
`define PDMC_A_MODULE_STOP_BIT 8'h0c
`define PDMC_A_STAT 8'h10
`define PDMC_AW 8
// field positions
`define PDMC_SBY_STANDBY_SELECT 7
`define PDMC_SBY_STS 4
`define PDMC_LPW_LOW_SPEED_ON 6
`define PDMC_TCS_PSS 4
`define PDMC_STAT_DIV 4
`define PDMC_STAT_BUSY 8
`define PDMC_MODULE_STOP_BIT_DTC 14
// reset values and masks
`define PDMC_MODULE_STOP_BIT_RST 16'h3fff
`define PDMC_MODULE_STOP_BIT_LIVE 16'h7bd8
`define PDMC_MODULE_STOP_BIT_NORET 16'h0ac0
`define PDMC_HW_STANDBY_PIN_LOSS 16'h08c0
`define PDMC_STS_RSV 3'h6
`define PDMC_STS_SHORT 3'h7
`define PDMC_DIV_MAX 3'h5
`endif

// ===== pdmc_pkg.sv
// types shared by the power-down mode controller
package pdmc_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_SLEEP = 3'b001,
    ST_SWSTBY = 3'b010,
    ST_SETTLE = 3'b011,
    ST_HWSTBY = 3'b100
  } pdmc_state_t;
endpackage : pdmc_pkg

// ===== pdmc_clk_div.sv
// divider making the bus master clock enable pulse, phi/1 to phi/32
`timescale 1ns/1ps
module pdmc_clk_div #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ratio select, 0 undivided, n divides by 2**n, at most by 2**WIDTH
  input wire logic [2:0] divSel,
  // enable pulse
  output logic divEn
);
  initial begin
    if (WIDTH < 5 || WIDTH > 7) $error("pdmc_clk_div: WIDTH out of range");
  end
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] mask;
  // mask of the low bits that must all be ones for a pulse
  assign mask = WIDTH'((1 << divSel) - 1);
  assign divEn = ((cnt_reg & mask) == mask);
  // free-running count; phase is not realigned on a ratio change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : pdmc_clk_div

// ===== pdmc_settle_cnt.sv
// oscillation settling down-counter in undivided clock states
`timescale 1ns/1ps
module pdmc_settle_cnt #(
  parameter int CW = 19
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // start with a length
  input wire logic load,
  input wire logic [CW-1:0] loadVal,
  // status
  output logic busy,
  output logic done
);
  initial begin
    if (CW < 5) $error("pdmc_settle_cnt: CW too small");
  end
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  assign busy = busy_reg;
  assign done = busy_reg && (cnt_reg == '0);
  // done comes loadVal - 1 cycles after the load edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= loadVal - 1'b1;
      busy_reg <= 1'b1;
    end else if (done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule : pdmc_settle_cnt

// ===== pdmc_power_ctl.sv
// power-down mode controller: clock division, sleep, module stop, standby
`timescale 1ns/1ps
`include "pdmc_defs.svh"
module pdmc_power_ctl #(
  parameter int SETTLE_BASE = 8192,
  parameter int SETTLE_SHORT = 16,
  parameter int CW = 19
) (
  // clock and reset pin
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // cpu and interrupt controller
  input wire logic sleepReq,
  input wire logic intDisable,
  input wire logic cpuMask,
  input wire logic irqReq,
  input wire logic nmiReq,
  input wire logic [2:0] extIrqReq,
  input wire logic [2:0] extIrqEn,
  input wire logic busCycleEnd,
  input wire logic dtcBusReq,
  // pins and watchdog
  input wire logic hwStandbyN,
  input wire logic wdtReset,
  // clock enables and oscillator
  output logic cpuClkEn,
  output logic dtcClkEn,
  output logic periphClkEn,
  output logic oscStop,
  // exception starts
  output logic intAccept,
  output logic resetExcStart,
  // peripheral controls
  output logic [15:0] moduleHalt,
  output logic [15:0] moduleClear,
  output logic [2:0] powerMode
);
  initial begin
    if (SETTLE_BASE < 1 || SETTLE_SHORT < 1) $error("pdmc: settle counts must be positive");
    if (longint'(SETTLE_BASE) * 32 >= (longint'(1) << CW)) $error("pdmc: CW too narrow");
    if (SETTLE_SHORT >= (1 << CW)) $error("pdmc: CW too narrow for short wait");
  end

  ////////////////////////////////////////////////////////////////////////////
  // settling length per code
  function automatic logic [CW-1:0] settleLen(input logic [2:0] code);
    logic [CW-1:0] base;
    base = CW'(SETTLE_BASE);
    if (code == `PDMC_STS_SHORT) begin
      settleLen = CW'(SETTLE_SHORT);
    end else if (code == `PDMC_STS_RSV) begin
      // reserved code takes the longest wait, safest for any oscillator
      settleLen = base << `PDMC_DIV_MAX;
    end else begin
      settleLen = base << code;
    end
  endfunction : settleLen

  ////////////////////////////////////////////////////////////////////////////
  // state and registers
  pdmc_pkg::pdmc_state_t state_reg;
  pdmc_pkg::pdmc_state_t stateNext;
  logic [2:0] divSel_reg;
  logic [2:0] stsSel_reg;
  logic standby_select_reg;
  logic low_speed_on_reg;
  logic pss_reg;
  logic [15:0] module_stop_bit_reg;
  logic [15:0] mstpNext;
  logic [2:0] activeDiv_reg;
  logic [15:0] halt_reg;
  logic [15:0] clear_reg;
  logic oscStop_reg;
  logic intAccept_reg;
  logic rstSeen_reg;
  logic resetExc_reg;
  logic wrPend_reg;
  logic [`PDMC_AW-1:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  // settling counter status; busy is read back through the status word
  logic settleBusy;
  logic settleDone;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic addrPhase;
  logic rdPhase;
  logic [`PDMC_AW-1:0] aAddr;
  logic wrSby;
  logic wrLpw;
  logic wrTcs;
  logic wrMstp;
  logic [31:0] rdMux;
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdPhase = addrPhase && !hwrite;
  assign aAddr = haddr[`PDMC_AW-1:0];
  assign wrSby = wrPend_reg && (wrAddr_reg == `PDMC_A_SBY);
  assign wrLpw = wrPend_reg && (wrAddr_reg == `PDMC_A_LPW);
  assign wrTcs = wrPend_reg && (wrAddr_reg == `PDMC_A_TCS);
  assign wrMstp = wrPend_reg && (wrAddr_reg == `PDMC_A_MODULE_STOP_BIT);
  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // read mux, unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (aAddr)
      `PDMC_A_SBY: begin
        rdMux[`PDMC_SBY_STANDBY_SELECT] = standby_select_reg;
        rdMux[`PDMC_SBY_STS +: 3] = stsSel_reg;
        rdMux[2:0] = divSel_reg;
      end
      `PDMC_A_LPW: rdMux[`PDMC_LPW_LOW_SPEED_ON] = low_speed_on_reg;
      `PDMC_A_TCS: rdMux[`PDMC_TCS_PSS] = pss_reg;
      `PDMC_A_MODULE_STOP_BIT: rdMux[15:0] = module_stop_bit_reg;
      `PDMC_A_STAT: begin
        rdMux[2:0] = state_reg;
        rdMux[`PDMC_STAT_DIV +: 3] = activeDiv_reg;
        rdMux[`PDMC_STAT_BUSY] = settleBusy;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // address phase capture; read data latched at the address edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= aAddr;
      if (rdPhase) begin
        hrdata_reg <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake and entry conditions
  logic softClr;
  logic goSleep;
  logic goStby;
  logic sleepWake;
  logic extWake;
  logic stbyWake;
  logic settleLoad;
  logic divEn;
  // watchdog reset and hardware standby act as a reset of the block
  assign softClr = !hwStandbyN || wdtReset;
  assign goSleep = sleepReq && !standby_select_reg && !low_speed_on_reg;
  assign goStby = sleepReq && standby_select_reg && !low_speed_on_reg && !pss_reg;
  // nmi passes the cpu mask, other requests do not
  assign sleepWake = !intDisable && (nmiReq || (irqReq && !cpuMask));
  assign extWake = |(extIrqReq & extIrqEn) && !cpuMask;
  assign stbyWake = nmiReq || extWake;
  assign settleLoad = (state_reg == pdmc_pkg::ST_SWSTBY) && stbyWake && !softClr;

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  always_comb begin
    stateNext = state_reg;
    unique case (state_reg)
      pdmc_pkg::ST_RUN: begin
        if (goSleep) begin
          stateNext = pdmc_pkg::ST_SLEEP;
        end else if (goStby) begin
          stateNext = pdmc_pkg::ST_SWSTBY;
        end
      end
      pdmc_pkg::ST_SLEEP: begin
        if (sleepWake) begin
          stateNext = pdmc_pkg::ST_RUN;
        end
      end
      pdmc_pkg::ST_SWSTBY: begin
        if (stbyWake) begin
          stateNext = pdmc_pkg::ST_SETTLE;
        end
      end
      pdmc_pkg::ST_SETTLE: begin
        if (settleDone) begin
          stateNext = pdmc_pkg::ST_RUN;
        end
      end
      // only the reset pin, or a watchdog reset once the standby pin is high, leaves hardware standby
      pdmc_pkg::ST_HWSTBY: stateNext = pdmc_pkg::ST_HWSTBY;
      default: stateNext = pdmc_pkg::ST_RUN;
    endcase
    if (!hwStandbyN) begin
      stateNext = pdmc_pkg::ST_HWSTBY;
    end else if (wdtReset) begin
      stateNext = pdmc_pkg::ST_RUN;
    end
  end

  // state, oscillator and exception pulses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= pdmc_pkg::ST_RUN;
      oscStop_reg <= 1'b0;
      intAccept_reg <= 1'b0;
    end else begin
      state_reg <= stateNext;
      oscStop_reg <= (stateNext == pdmc_pkg::ST_SWSTBY);
      intAccept_reg <= (stateNext == pdmc_pkg::ST_RUN) && !softClr &&
                       (state_reg == pdmc_pkg::ST_SLEEP || state_reg == pdmc_pkg::ST_SETTLE);
    end
  end

  // one pulse at the first edge after the reset pin is released
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSeen_reg <= 1'b0;
      resetExc_reg <= 1'b0;
    end else begin
      rstSeen_reg <= 1'b1;
      resetExc_reg <= !rstSeen_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  // a pending transfer controller request stops its stop bit from rising
  always_comb begin
    mstpNext = hwdata[15:0];
    if (dtcBusReq && !module_stop_bit_reg[`PDMC_MODULE_STOP_BIT_DTC]) begin
      mstpNext[`PDMC_MODULE_STOP_BIT_DTC] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divSel_reg <= 3'h0;
      stsSel_reg <= 3'h0;
      standby_select_reg <= 1'b0;
      low_speed_on_reg <= 1'b0;
      pss_reg <= 1'b0;
      module_stop_bit_reg <= `PDMC_MODULE_STOP_BIT_RST;
    end else if (softClr) begin
      divSel_reg <= 3'h0;
      stsSel_reg <= 3'h0;
      standby_select_reg <= 1'b0;
      low_speed_on_reg <= 1'b0;
      pss_reg <= 1'b0;
      module_stop_bit_reg <= `PDMC_MODULE_STOP_BIT_RST;
    end else begin
      if (wrSby) begin
        divSel_reg <= hwdata[2:0];
        stsSel_reg <= hwdata[`PDMC_SBY_STS +: 3];
        standby_select_reg <= hwdata[`PDMC_SBY_STANDBY_SELECT];
      end
      if (wrLpw) begin
        low_speed_on_reg <= hwdata[`PDMC_LPW_LOW_SPEED_ON];
      end
      if (wrTcs) begin
        pss_reg <= hwdata[`PDMC_TCS_PSS];
      end
      if (wrMstp) begin
        module_stop_bit_reg <= mstpNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // division and module stop, applied at bus cycle boundaries
  logic [2:0] divClamp;
  logic [15:0] haltNext;
  // ratios beyond phi/32 are not defined; clamp rather than stall the cpu
  assign divClamp = (divSel_reg > `PDMC_DIV_MAX) ? `PDMC_DIV_MAX : divSel_reg;
  assign haltNext = softClr ? (`PDMC_MODULE_STOP_BIT_RST & `PDMC_MODULE_STOP_BIT_LIVE)
                            : (module_stop_bit_reg & `PDMC_MODULE_STOP_BIT_LIVE);

  // sleep and software standby leave the ratio untouched so it is restored on wake; hardware standby clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      activeDiv_reg <= 3'h0;
    end else if (softClr) begin
      activeDiv_reg <= 3'h0;
    end else if (busCycleEnd && state_reg == pdmc_pkg::ST_RUN) begin
      activeDiv_reg <= divClamp;
    end
  end

  // stop bits act at the end of the bus cycle; unit clears for lost state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halt_reg <= `PDMC_MODULE_STOP_BIT_RST & `PDMC_MODULE_STOP_BIT_LIVE;
      clear_reg <= `PDMC_MODULE_STOP_BIT_NORET;
    end else begin
      if (busCycleEnd || softClr) begin
        halt_reg <= haltNext;
      end
      clear_reg <= ((busCycleEnd || softClr ? haltNext : halt_reg) & `PDMC_MODULE_STOP_BIT_NORET) |
                   ((stateNext == pdmc_pkg::ST_SWSTBY) ? `PDMC_HW_STANDBY_PIN_LOSS : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enables
  pdmc_clk_div #(.WIDTH(5)) u_div (
    .clk(clk),
    .nrst(nrst),
    .divSel(activeDiv_reg),
    .divEn(divEn)
  );

  pdmc_settle_cnt #(.CW(CW)) u_settle (
    .clk(clk),
    .nrst(nrst),
    .load(settleLoad),
    .loadVal(settleLen(stsSel_reg)),
    .busy(settleBusy),
    .done(settleDone)
  );

  // every bus master state is one divided clock, so accesses stretch with it
  assign cpuClkEn = (state_reg == pdmc_pkg::ST_RUN) && divEn;
  assign dtcClkEn = cpuClkEn && !halt_reg[`PDMC_MODULE_STOP_BIT_DTC];
  assign periphClkEn = (state_reg == pdmc_pkg::ST_RUN) ||
                       (state_reg == pdmc_pkg::ST_SLEEP);
  assign oscStop = oscStop_reg;
  assign intAccept = intAccept_reg;
  assign resetExcStart = resetExc_reg;
  assign moduleHalt = halt_reg;
  assign moduleClear = clear_reg;
  assign powerMode = state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic dtcSetClash;
  assign dtcSetClash = wrMstp && hwdata[`PDMC_MODULE_STOP_BIT_DTC] && dtcBusReq && !module_stop_bit_reg[`PDMC_MODULE_STOP_BIT_DTC];

  property p_hw_standby_pin_osc;
    state_reg == pdmc_pkg::ST_SWSTBY |-> oscStop && !periphClkEn && !cpuClkEn;
  endproperty
  a_hw_standby_pin_osc: assert property (p_hw_standby_pin_osc) else $error("standby with clocks on");

  property p_settle_gate;
    state_reg == pdmc_pkg::ST_SETTLE |-> !oscStop && !periphClkEn && !cpuClkEn;
  endproperty
  a_settle_gate: assert property (p_settle_gate) else $error("clocks during settling");

  // cycles spent in settling; a counter keeps the check valid for any short length
  logic [CW-1:0] settleAge_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settleAge_reg <= '0;
    end else if (state_reg != pdmc_pkg::ST_SETTLE) begin
      settleAge_reg <= '0;
    end else begin
      settleAge_reg <= settleAge_reg + 1'b1;
    end
  end

  property p_settle_short;
    state_reg == pdmc_pkg::ST_SETTLE && settleDone && stsSel_reg == `PDMC_STS_SHORT
      |-> settleAge_reg == CW'(SETTLE_SHORT - 1);
  endproperty
  a_settle_short: assert property (p_settle_short) else $error("short wait ended early");

  property p_settle_end;
    state_reg == pdmc_pkg::ST_SETTLE && settleDone && hwStandbyN && !wdtReset
      |=> state_reg == pdmc_pkg::ST_RUN && intAccept && periphClkEn;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("no wake after settling");

  property p_sleep_clk;
    state_reg == pdmc_pkg::ST_SLEEP |-> !cpuClkEn && periphClkEn;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clock enables wrong");

  property p_sleep_wake;
    state_reg == pdmc_pkg::ST_SLEEP && sleepWake && hwStandbyN && !wdtReset
      |=> state_reg == pdmc_pkg::ST_RUN && intAccept;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left on interrupt");

  property p_hw_standby_pin_hold;
    state_reg == pdmc_pkg::ST_SWSTBY && !stbyWake && hwStandbyN && !wdtReset
      |=> state_reg == pdmc_pkg::ST_SWSTBY;
  endproperty
  a_hw_standby_pin_hold: assert property (p_hw_standby_pin_hold) else $error("standby left without wake");

  property p_hw_hw_standby_pin;
    !hwStandbyN |=> state_reg == pdmc_pkg::ST_HWSTBY && module_stop_bit_reg == `PDMC_MODULE_STOP_BIT_RST;
  endproperty
  a_hw_hw_standby_pin: assert property (p_hw_hw_standby_pin) else $error("hardware standby not taken");

  property p_wdt_div;
    wdtReset |=> activeDiv_reg == 3'h0 && state_reg == pdmc_pkg::ST_RUN;
  endproperty
  a_wdt_div: assert property (p_wdt_div) else $error("watchdog kept medium speed");

  property p_halt_edge;
    !busCycleEnd && !softClr |=> $stable(moduleHalt);
  endproperty
  a_halt_edge: assert property (p_halt_edge) else $error("halt moved mid bus cycle");

  property p_div_edge;
    !busCycleEnd && !softClr |=> $stable(activeDiv_reg);
  endproperty
  a_div_edge: assert property (p_div_edge) else $error("ratio moved mid bus cycle");

  property p_dtc_wins;
    dtcSetClash && hwStandbyN && !wdtReset |=> !module_stop_bit_reg[`PDMC_MODULE_STOP_BIT_DTC];
  endproperty
  a_dtc_wins: assert property (p_dtc_wins) else $error("stop bit set during request");

  c_sleep_cycle: cover property (state_reg == pdmc_pkg::ST_SLEEP ##[1:50] intAccept);
  c_hw_standby_pin_cycle: cover property (state_reg == pdmc_pkg::ST_SETTLE ##[1:40] intAccept);
  c_medium: cover property (activeDiv_reg == 3'h2 && cpuClkEn);
  c_dtc_clash: cover property (dtcSetClash);
endmodule : pdmc_power_ctl

// ===== pdmc_irq_model.sv
// interrupt source and bus cycle model standing on the cpu side of the controller
`timescale 1ns/1ps
module pdmc_irq_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench raises and the controller's acceptance
  input wire logic raiseIrq,
  input wire logic raiseNmi,
  input wire logic intAccept,
  // towards the controller
  output logic irqReq,
  output logic nmiReq,
  output logic busCycleEnd
);
  logic [1:0] phase_reg;
  logic irqHeld_reg;
  logic nmiHeld_reg;
  ////////////////////////////////////////
  // four-state bus cycles, so halt and ratio updates land on known edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 2'h0;
      irqHeld_reg <= 1'b0;
      nmiHeld_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      irqHeld_reg <= (irqHeld_reg | raiseIrq) & ~intAccept;
      nmiHeld_reg <= (nmiHeld_reg | raiseNmi) & ~intAccept;
    end
  end
  // a request stays up until accepted; a raise shows in its own cycle
  assign busCycleEnd = (phase_reg == 2'h3);
  assign irqReq = irqHeld_reg | raiseIrq;
  assign nmiReq = nmiHeld_reg | raiseNmi;
endmodule : pdmc_irq_model

// ===== test_power_down_mode_control.sv
// self-checking bench for the power-down mode controller
`timescale 1ns/1ps
`include "pdmc_defs.svh"
module test_power_down_mode_control;
  logic clk, nrst, hsel, hwrite, hreadyout, hresp, sleepReq, intDisable, cpuMask;
  logic irqReq, nmiReq, busCycleEnd, dtcBusReq, hwStandbyN, wdtReset, cpuClkEn;
  logic dtcClkEn, periphClkEn, oscStop, intAccept, resetExcStart, raiseIrq, raiseNmi;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, extIrqReq, extIrqEn, powerMode, dv;
  logic [15:0] moduleHalt, moduleClear, module_stop_bit;
  logic [31:0] rdQ[$];
  int n_mismatch, total_checks, cnt, cntD;
  event rdDone;
  ////////////////////////////////////////
  pdmc_power_ctl #(.SETTLE_BASE(8), .SETTLE_SHORT(4), .CW(19)) u_dut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sleepReq(sleepReq), .intDisable(intDisable),
    .cpuMask(cpuMask), .irqReq(irqReq), .nmiReq(nmiReq), .extIrqReq(extIrqReq),
    .extIrqEn(extIrqEn), .busCycleEnd(busCycleEnd), .dtcBusReq(dtcBusReq),
    .hwStandbyN(hwStandbyN), .wdtReset(wdtReset), .cpuClkEn(cpuClkEn),
    .dtcClkEn(dtcClkEn), .periphClkEn(periphClkEn), .oscStop(oscStop),
    .intAccept(intAccept), .resetExcStart(resetExcStart), .moduleHalt(moduleHalt),
    .moduleClear(moduleClear), .powerMode(powerMode));
  pdmc_irq_model u_cpu (.clk(clk), .nrst(nrst), .raiseIrq(raiseIrq), .raiseNmi(raiseNmi),
    .intAccept(intAccept), .irqReq(irqReq), .nmiReq(nmiReq), .busCycleEnd(busCycleEnd));
  ////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // single ahb-lite word transfer; a read notes its expected word for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w) rdQ.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (!w) ->rdDone;
  endtask : bus
  // read data is only valid at the data-phase edge, so compare it right there
  always @(rdDone) chk("hrdata", rdQ.pop_front(), hrdata);
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic waitMode(input logic [2:0] m, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (powerMode !== m);
  endtask : waitMode
  task automatic sleepOp(input logic [2:0] m);
    @(posedge clk) sleepReq <= 1'b1;
    @(posedge clk) sleepReq <= 1'b0;
    #1 chk("mode", 32'(m), 32'(powerMode));
  endtask : sleepOp
  // watchdog sized well above the whole sequence
  initial begin
    #(20000 * 100);
    n_mismatch++;
    close_out();
  end
  ////////////////////////////////////////
  initial begin
    {hsel, hwrite, sleepReq, intDisable, cpuMask, dtcBusReq, wdtReset} = '0;
    {raiseIrq, raiseNmi, nrst, haddr, hwdata, htrans} = '0;
    hwStandbyN = 1'b1;
    {extIrqReq, extIrqEn, hsize} = 9'h2;
    cnt = $urandom(4781);
    repeat (8) @(posedge clk);
    #1 chk("haltInReset", 32'h3bd8, 32'(moduleHalt));
    @(posedge clk) nrst <= 1'b1;
    @(posedge clk) #1 chk("resetExc", 32'h1, 32'(resetExcStart));
    bus(1'b0, `PDMC_A_MODULE_STOP_BIT, 32'h3fff);
    bus(1'b0, 8'h14, 32'h0);
    $display("reset test done");
    // bit 15 is never set by software
    module_stop_bit = 16'($urandom) & 16'h3fff;
    bus(1'b1, `PDMC_A_MODULE_STOP_BIT, {16'h0, module_stop_bit});
    bus(1'b0, `PDMC_A_MODULE_STOP_BIT, {16'h0, module_stop_bit});
    tick(8);
    chk("halt", 32'(module_stop_bit & 16'h7bd8), 32'(moduleHalt));
    chk("clear", 32'(module_stop_bit & 16'h0ac0), 32'(moduleClear));
    dv = 3'(1 + $urandom % 5);
    bus(1'b1, `PDMC_A_SBY, {29'h0, dv});
    tick(8);
    bus(1'b0, `PDMC_A_STAT, {25'h0, dv, 4'h0});
    cnt = 0;
    cntD = 0;
    repeat (64) begin
      tick(1);
      if (cpuClkEn === 1'b1) cnt++;
      if (dtcClkEn === 1'b1) cntD++;
    end
    chk("cpuClk", 32'(64 >> dv), 32'(cnt));
    chk("dtcClk", 32'(64 >> dv), 32'(cntD));
    chk("periphClk", 32'h1, 32'(periphClkEn));
    // a stop request colliding with a transfer request is dropped; software retries
    @(posedge clk) dtcBusReq <= 1'b1;
    bus(1'b1, `PDMC_A_MODULE_STOP_BIT, {16'h0, module_stop_bit | 16'h4000});
    bus(1'b0, `PDMC_A_MODULE_STOP_BIT, {16'h0, module_stop_bit});
    @(posedge clk) dtcBusReq <= 1'b0;
    module_stop_bit = module_stop_bit | 16'h4000;
    bus(1'b1, `PDMC_A_MODULE_STOP_BIT, {16'h0, module_stop_bit});
    tick(8);
    chk("dtcHalt", 32'h1, 32'(moduleHalt[14]));
    chk("dtcClkOff", 32'h0, 32'(dtcClkEn));
    $display("module stop and medium speed test done");
    sleepOp(3'h1);
    @(posedge clk);
    cpuMask <= 1'b1;
    raiseIrq <= 1'b1;
    @(posedge clk) raiseIrq <= 1'b0;
    tick(6);
    chk("maskedStay", 32'h1, 32'(powerMode));
    @(posedge clk) cpuMask <= 1'b0;
    waitMode(3'h0, cnt);
    chk("irqWake", 32'h1, 32'(cnt));
    chk("irqAccept", 32'h1, 32'(intAccept));
    sleepOp(3'h1);
    @(posedge clk);
    intDisable <= 1'b1;
    raiseNmi <= 1'b1;
    @(posedge clk) raiseNmi <= 1'b0;
    tick(6);
    chk("disabledStay", 32'h1, 32'(powerMode));
    @(posedge clk) intDisable <= 1'b0;
    waitMode(3'h0, cnt);
    chk("nmiWake", 32'h1, 32'(cnt));
    bus(1'b0, `PDMC_A_STAT, {25'h0, dv, 4'h0});
    $display("sleep test done");
    // every settling code but the reserved one; external clock, so any code is legal
    for (int c = 0; c < 8; c++) begin
      if (c == 6) continue;
      bus(1'b1, `PDMC_A_SBY, {24'h0, 1'b1, 3'(c), 1'b0, dv});
      sleepOp(3'h2);
      chk("oscStop", 32'h1, 32'(oscStop));
      chk("lost", 32'((module_stop_bit & 16'h0ac0) | 16'h08c0), 32'(moduleClear));
      @(posedge clk);
      extIrqReq <= 3'(1 << (c % 3));
      cpuMask <= 1'b1;
      tick(3);
      chk("offStay", 32'h2, 32'(powerMode));
      @(posedge clk) extIrqEn <= 3'h7;
      tick(3);
      chk("maskStay", 32'h2, 32'(powerMode));
      @(posedge clk);
      if (c == 7) raiseNmi <= 1'b1;
      else cpuMask <= 1'b0;
      @(posedge clk) raiseNmi <= 1'b0;
      #1 chk("settling", 32'h3, 32'(powerMode));
      chk("oscRun", 32'h0, 32'(oscStop));
      waitMode(3'h0, cnt);
      chk("settleLen", (c == 7) ? 32'h4 : 32'(8 << c), 32'(cnt));
      chk("wakeAccept", 32'h1, 32'(intAccept));
      @(posedge clk);
      extIrqReq <= 3'h0;
      extIrqEn <= 3'h0;
      cpuMask <= 1'b0;
    end
    bus(1'b0, `PDMC_A_STAT, {25'h0, dv, 4'h0});
    bus(1'b0, `PDMC_A_MODULE_STOP_BIT, {16'h0, module_stop_bit});
    $display("software standby test done");
    sleepOp(3'h2);
    @(posedge clk) nrst <= 1'b0;
    #1 chk("rstOsc", 32'h0, 32'(oscStop));
    chk("rstClk", 32'h1, 32'(periphClkEn));
    tick(8);
    @(posedge clk) nrst <= 1'b1;
    @(posedge clk) #1 chk("resetExc", 32'h1, 32'(resetExcStart));
    bus(1'b0, `PDMC_A_STAT, 32'h0);
    bus(1'b1, `PDMC_A_SBY, {29'h0, dv});
    tick(8);
    bus(1'b1, `PDMC_A_SBY, 32'h0);
    tick(8);
    bus(1'b0, `PDMC_A_STAT, 32'h0);
    bus(1'b1, `PDMC_A_SBY, {29'h0, dv});
    tick(8);
    bus(1'b0, `PDMC_A_STAT, {25'h0, dv, 4'h0});
    @(posedge clk) wdtReset <= 1'b1;
    @(posedge clk) wdtReset <= 1'b0;
    tick(8);
    bus(1'b0, `PDMC_A_STAT, 32'h0);
    $display("reset cancel test done");
    @(posedge clk) hwStandbyN <= 1'b0;
    tick(2);
    chk("hwStandby", 32'h4, 32'(powerMode));
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) hwStandbyN <= 1'b1;
    tick(8);
    @(posedge clk) nrst <= 1'b1;
    tick(2);
    chk("hwLeave", 32'h0, 32'(powerMode));
    bus(1'b0, `PDMC_A_MODULE_STOP_BIT, 32'h3fff);
    $display("hardware standby test done");
    close_out();
  end
endmodule : test_power_down_mode_control
